/* common/wdt_map.svh */
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define WDT_CLEAR_ADDR 16'hFFFF
`define WDT_VEC_HI_ADDR 16'hFFFE
`define WDT_CAUSE_ADDR 16'hFE01
`define WDT_MASK_ADDR 16'hFE02
`define WDT_STATE_ADDR 16'hFE03

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WDT_CAUSE_TIMEOUT 0
`define WDT_CAUSE_HOLD 1
`define WDT_STATE_FIRING 0
`define WDT_STATE_DISABLED 1
`define WDT_STATE_STOPPED 2

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define WDT_MASK_RESET 2'h0
`define WDT_CAUSE_RESET 2'h0
`define WDT_RDATA_RESET 8'h00
`define WDT_PULSE_CYCLES 6'h20
`define WDT_POR_CYCLES 13'h1000
`define WDT_PRESC_BITS 12
`define WDT_COUNT_BITS 6
`define WDT_KEEP_BITS 3
`define WDT_TAP_LOW 4
`define WDT_SHORT_TAP 12

`endif

/* common/wdt_pkg.sv */
package wdt_pkg;

    // Register access request as seen by the slave
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // Sources that may hold the watchdog off
    typedef struct packed {
        logic config_off;
        logic monitor_hv;
        logic break_hv;
    } hold_src_t;

    // Watchdog sequencing
    typedef enum logic [0:0] {
        WD_RUN,
        WD_FIRE
    } wd_state_t;

endpackage

/* rtl/wdt_sync.sv */
`timescale 1ns/10ps

module wdt_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Asynchronous levels in, synchronous levels out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    genvar i;

    // Two stages per bit; the first stage feeds only the second
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta;
            logic stage2;
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    meta <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    meta <= async_i[i];
                    stage2 <= meta;
                end
            end
            // Each bit has its own flop, so no two processes share the output vector
            assign sync_o[i] = stage2;
        end
    endgenerate

endmodule

/* rtl/watchdog_timeout_reset.sv */
// Functional notes
// - Free-running 6-bit counter behind a 12-bit prescaler, clocked by crystal clock.
// - Unserviced watchdog fires reset after 2^13-16 or 2^18-16 crystal cycles.
// - Any write to clear location zeroes counter and prescaler stages 4 to 12.
// - Reading the clear location returns the reset vector low byte, not state.
// - Timeout drives reset pin low 32 cycles and sets watchdog cause flag.
// - Monitor mode with high test voltage on interrupt or reset pin disables.
// - Break state with high test voltage on reset pin disables the watchdog.
// - Stop instruction clears prescaler; stop mode halts counting entirely.
// - Prescaler is cleared 4096 crystal cycles after power comes up.
// - Internal reset clears both prescaler and counter.
// - Reset vector fetch on the bus clears the prescaler.
// - Disable and rate-select inputs come from configuration register bits.
// - Watchdog never requests a CPU interrupt; its only action is reset.
// - Counting continues through wait mode.
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`include "wdt_map.svh"

module watchdog_timeout_reset
    import wdt_pkg::*;
#(
    parameter int PRESC_BITS = `WDT_PRESC_BITS,
    parameter int COUNT_BITS = `WDT_COUNT_BITS
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    // Register port
    input wire logic [15:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // Reset vector low byte from program memory
    input wire logic [7:0] RESET_VECTOR_LO_I,
    // Configuration bits
    input wire logic WATCHDOG_DISABLE_BIT_I,
    input wire logic LONG_TIMEOUT_SELECT_I,
    // System integration unit status
    input wire logic MONITOR_MODE_I,
    input wire logic BREAK_STATE_I,
    input wire logic WAIT_MODE_I,
    input wire logic STOP_MODE_I,
    input wire logic STOP_EXEC_I,
    input wire logic INTERNAL_RESET_I,
    // High test voltage detectors on pins
    input wire logic HV_IRQ_PIN_I,
    input wire logic HV_RST_PIN_I,
    // External reset pin, open drain
    input wire logic RST_PIN_I,
    output logic RST_PIN_O,
    output logic RST_PIN_OE_O,
    // Reset request and cause event to the system reset logic
    output logic WDOG_RESET_O,
    output logic CAUSE_EVENT_O
);

    localparam int TOTAL_BITS = PRESC_BITS + COUNT_BITS;

    // ------------------------------------------------------------------
    // Input capture
    // ------------------------------------------------------------------
    bus_req_t req;
    logic [2:0] pin_sync;
    logic hv_irq;
    logic hv_rst;

    // Bus port is already in this clock domain
    assign req.addr = ADDR_I;
    assign req.wdata = WDATA_I;
    assign req.wr = WR_I;
    assign req.rd = RD_I;

    // Pin-level detectors are asynchronous to the crystal clock
    wdt_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk_i(SYS_CLK_I),
        .nrst_i(NRST_I),
        .async_i({RST_PIN_I, HV_RST_PIN_I, HV_IRQ_PIN_I}),
        .sync_o(pin_sync)
    );
    assign hv_irq = pin_sync[0];
    assign hv_rst = pin_sync[1];

    // ------------------------------------------------------------------
    // Disable and service decode
    // ------------------------------------------------------------------
    hold_src_t hold;
    logic disabled;
    logic clear_wr;
    logic vector_fetch;
    logic presc_clr;
    logic timeout_hit;
    logic por_clear;

    // Any of the hold sources keeps the watchdog idle
    assign hold.config_off = WATCHDOG_DISABLE_BIT_I;
    assign hold.monitor_hv = MONITOR_MODE_I && (hv_irq || hv_rst);
    assign hold.break_hv = BREAK_STATE_I && hv_rst;
    assign disabled = |hold;

    // Data value is ignored: the write itself is the service
    assign clear_wr = req.wr && (req.addr == `WDT_CLEAR_ADDR);
    // Vector fetch is seen as a read of the reset vector bytes
    assign vector_fetch = req.rd && ((req.addr == `WDT_VEC_HI_ADDR) ||
                                     (req.addr == `WDT_CLEAR_ADDR));
    assign presc_clr = STOP_EXEC_I || por_clear || vector_fetch;

    // ------------------------------------------------------------------
    // Power-up prescaler clear
    // ------------------------------------------------------------------
    logic [12:0] por_cnt;
    logic por_done;

    // One-shot clear once the power-up delay has elapsed
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            por_cnt <= 13'h0000;
            por_done <= 1'b0;
        end else if (!por_done) begin
            if (por_cnt == `WDT_POR_CYCLES - 13'h0001) begin
                por_done <= 1'b1;
            end
            por_cnt <= por_cnt + 13'h0001;
        end
    end
    assign por_clear = !por_done && (por_cnt == `WDT_POR_CYCLES - 13'h0001);

    // ------------------------------------------------------------------
    // Prescaler and counter chain
    // ------------------------------------------------------------------
    logic [TOTAL_BITS-1:0] chain;
    logic [TOTAL_BITS-1:0] next_chain;
    logic long_hit;
    logic short_hit;
    wd_state_t state;

    // Prescaler in the low bits, watchdog counter in the high bits
    always_comb begin
        next_chain = chain + {{(TOTAL_BITS-1){1'b0}}, 1'b1};
        if (INTERNAL_RESET_I || disabled || state == WD_FIRE) begin
            next_chain = '0;
        end else if (STOP_MODE_I) begin
            // No crystal clock reaches the chain in stop mode
            next_chain = chain;
            if (STOP_EXEC_I) begin
                next_chain[PRESC_BITS-1:0] = '0;
            end
        end else begin
            if (clear_wr) begin
                // Low stages keep running so service is glitch free
                next_chain[TOTAL_BITS-1:`WDT_KEEP_BITS] = '0;
            end
            if (presc_clr) begin
                next_chain[PRESC_BITS-1:0] = '0;
            end
        end
    end

    // Chain register
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            chain <= '0;
        end else begin
            chain <= next_chain;
        end
    end

    // Terminal counts sit 16 cycles short of the power of two
    assign long_hit = &chain[TOTAL_BITS-1:`WDT_TAP_LOW];
    assign short_hit = &chain[`WDT_SHORT_TAP:`WDT_TAP_LOW];
    assign timeout_hit = (state == WD_RUN) && !disabled && !STOP_MODE_I &&
                         !INTERNAL_RESET_I && !clear_wr &&
                         (LONG_TIMEOUT_SELECT_I ? short_hit : long_hit);

    // ------------------------------------------------------------------
    // Reset pulse sequencing
    // ------------------------------------------------------------------
    logic [5:0] pulse_cnt;

    // Fire holds the reset for a fixed number of crystal cycles
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state <= WD_RUN;
            pulse_cnt <= 6'h00;
        end else begin
            case (state)
                WD_RUN: begin
                    pulse_cnt <= 6'h00;
                    if (timeout_hit) begin
                        state <= WD_FIRE;
                    end
                end
                WD_FIRE: begin
                    pulse_cnt <= pulse_cnt + 6'h01;
                    if (pulse_cnt == `WDT_PULSE_CYCLES - 6'h01) begin
                        state <= WD_RUN;
                    end
                end
                default: begin
                    state <= WD_RUN;
                    pulse_cnt <= 6'h00;
                end
            endcase
        end
    end

    // Pin and reset request straight from flops
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RST_PIN_O <= 1'b0;
            RST_PIN_OE_O <= 1'b0;
            WDOG_RESET_O <= 1'b0;
        end else begin
            RST_PIN_O <= 1'b0; // Open drain only ever pulls low
            RST_PIN_OE_O <= timeout_hit ||
                            (state == WD_FIRE &&
                             pulse_cnt != `WDT_PULSE_CYCLES - 6'h01);
            WDOG_RESET_O <= timeout_hit ||
                            (state == WD_FIRE &&
                             pulse_cnt != `WDT_PULSE_CYCLES - 6'h01);
        end
    end

    // ------------------------------------------------------------------
    // Cause flags and mask
    // ------------------------------------------------------------------
    logic [1:0] cause;
    logic [1:0] mask;
    logic [1:0] cause_set;
    logic cause_rd;
    logic hold_prev;

    assign cause_rd = req.rd && (req.addr == `WDT_CAUSE_ADDR);

    // Track entry into a monitor or break held-off state
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            hold_prev <= 1'b0;
        end else begin
            hold_prev <= hold.monitor_hv || hold.break_hv;
        end
    end

    always_comb begin
        cause_set = 2'h0;
        cause_set[`WDT_CAUSE_TIMEOUT] = timeout_hit;
        cause_set[`WDT_CAUSE_HOLD] = (hold.monitor_hv || hold.break_hv) && !hold_prev;
    end

    // Read clears; a set in the same cycle wins over the clear
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cause <= `WDT_CAUSE_RESET;
        end else begin
            cause <= (cause_rd ? 2'h0 : cause) | cause_set;
        end
    end

    // Mask register
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            mask <= `WDT_MASK_RESET;
        end else if (req.wr && req.addr == `WDT_MASK_ADDR) begin
            mask <= req.wdata[1:0];
        end
    end

    // Event line goes to the reset logic, never to the CPU
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            CAUSE_EVENT_O <= 1'b0;
        end else begin
            CAUSE_EVENT_O <= |(((cause_rd ? 2'h0 : cause) | cause_set) & mask);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [7:0] next_rdata;

    // Clear location reflects vector contents, nothing held here
    always_comb begin
        next_rdata = `WDT_RDATA_RESET;
        if (req.rd) begin
            case (req.addr)
                `WDT_CLEAR_ADDR: next_rdata = RESET_VECTOR_LO_I;
                `WDT_CAUSE_ADDR: next_rdata = {6'h00, cause};
                `WDT_MASK_ADDR: next_rdata = {6'h00, mask};
                `WDT_STATE_ADDR: begin
                    next_rdata[`WDT_STATE_FIRING] = (state == WD_FIRE);
                    next_rdata[`WDT_STATE_DISABLED] = disabled;
                    next_rdata[`WDT_STATE_STOPPED] = STOP_MODE_I;
                    next_rdata[7:3] = chain[TOTAL_BITS-1:TOTAL_BITS-5];
                end
                default: next_rdata = `WDT_RDATA_RESET;
            endcase
        end
    end

    // Data stands one cycle after the read strobe only
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RDATA_O <= `WDT_RDATA_RESET;
        end else begin
            RDATA_O <= next_rdata;
        end
    end

    // Wait mode and the synchronised pin level are observed but change nothing
    logic unused_ok;
    assign unused_ok = WAIT_MODE_I ^ pin_sync[2];

endmodule

/* test/watchdog_timeout_reset_assertions.sv */
`timescale 1ns/10ps

module wdt_checker (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    // Register port
    input wire logic [15:0] ADDR_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic [7:0] RESET_VECTOR_LO_I,
    // Configuration and modes
    input wire logic WATCHDOG_DISABLE_BIT_I,
    input wire logic LONG_TIMEOUT_SELECT_I,
    input wire logic STOP_MODE_I,
    input wire logic INTERNAL_RESET_I,
    // Reset outputs
    input wire logic RST_PIN_O,
    input wire logic RST_PIN_OE_O,
    input wire logic WDOG_RESET_O
);
    // Service keeps bits 2:0; the floors sit 16 cycles (short) and 8 cycles (long) below the timeouts
    localparam int SHORT_MIN = 8160;
    localparam int LONG_MIN = 262120;
    logic [5:0] high_cnt;
    logic [18:0] since;

    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);

    // Length of the current reset pulse
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            high_cnt <= 6'h00;
        end else if (WDOG_RESET_O) begin
            high_cnt <= high_cnt + 6'h01;
        end else begin
            high_cnt <= 6'h00;
        end
    end

    // Bound on the chain: reset, the reset pulse, internal reset and service restart it, saturating so it never wraps
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            since <= 19'h00000;
        end else if (WDOG_RESET_O || INTERNAL_RESET_I || (WR_I && ADDR_I == 16'hFFFF)) begin
            since <= 19'h00000;
        end else if (!since[18]) begin
            since <= since + 19'h00001;
        end
    end

    sequence vec_read_s;
        RD_I && ADDR_I == 16'hFFFF;
    endsequence
    sequence quiet_s;
        !WDOG_RESET_O [*8];
    endsequence

    pulse_len_a: assert property ($fell(WDOG_RESET_O) |-> high_cnt == 6'h20)
        else $error("reset pulse length wrong");
    oe_match_a: assert property (RST_PIN_OE_O == WDOG_RESET_O)
        else $error("pin drive and reset request differ");
    pin_low_a: assert property (RST_PIN_OE_O |-> RST_PIN_O == 1'b0)
        else $error("reset pin not driven low");
    read_idle_a: assert property (!RD_I |=> RDATA_O == 8'h00)
        else $error("read data without a read");
    vec_read_a: assert property (vec_read_s |=> RDATA_O == $past(RESET_VECTOR_LO_I))
        else $error("clear location read is not the vector byte");
    fire_cause_a: assert property ($rose(WDOG_RESET_O) |->
        !$past(WATCHDOG_DISABLE_BIT_I) && !$past(STOP_MODE_I) && !$past(INTERNAL_RESET_I))
        else $error("reset while held off");
    fire_time_a: assert property ($rose(WDOG_RESET_O) |->
        since >= (LONG_TIMEOUT_SELECT_I ? SHORT_MIN : LONG_MIN))
        else $error("timeout came too early");
    pulse_gap_a: assert property ($fell(WDOG_RESET_O) |-> quiet_s)
        else $error("new reset right after a pulse");
endmodule

bind watchdog_timeout_reset wdt_checker u_wdt_checker (
    .SYS_CLK_I(SYS_CLK_I),
    .NRST_I(NRST_I),
    .ADDR_I(ADDR_I),
    .WR_I(WR_I),
    .RD_I(RD_I),
    .RDATA_O(RDATA_O),
    .RESET_VECTOR_LO_I(RESET_VECTOR_LO_I),
    .WATCHDOG_DISABLE_BIT_I(WATCHDOG_DISABLE_BIT_I),
    .LONG_TIMEOUT_SELECT_I(LONG_TIMEOUT_SELECT_I),
    .STOP_MODE_I(STOP_MODE_I),
    .INTERNAL_RESET_I(INTERNAL_RESET_I),
    .RST_PIN_O(RST_PIN_O),
    .RST_PIN_OE_O(RST_PIN_OE_O),
    .WDOG_RESET_O(WDOG_RESET_O)
);

/* test/wdt_reset_partner.sv */
`timescale 1ns/10ps

module wdt_reset_partner (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Pin drive and reset request from the watchdog
    input wire logic pin_oe_i,
    input wire logic pin_drive_i,
    input wire logic wdog_reset_i,
    // Resolved pin and internal reset back to it
    output logic pin_level_o,
    output logic internal_reset_o
);
    logic seen;
    logic [2:0] hold;

    // Pull-up wins unless the open-drain driver pulls low
    assign pin_level_o = pin_oe_i ? pin_drive_i : 1'b1;
    assign internal_reset_o = (hold != 3'h0);

    // Four cycles of internal reset once the external pulse ends
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seen <= 1'b0;
            hold <= 3'h0;
        end else begin
            seen <= wdog_reset_i;
            if (seen && !wdog_reset_i) begin
                hold <= 3'h4;
            end else if (hold != 3'h0) begin
                hold <= hold - 3'h1;
            end
        end
    end
endmodule

/* test/test_watchdog_timeout_reset.sv */
`timescale 1ns/10ps

module test_watchdog_timeout_reset;
    logic clk, nrst, wr, rd, dis, lng, mon, brk, wt, stp, sexec, irst, hvi, hvr;
    logic pin, oe, pdrv, wrst, cev;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, vec, m;
    int miscompares, comparisons, cyc, n;
    // Hold modes: {long off, disable, monitor, break, hv irq, hv rst, stop}
    logic [6:0] modes [6] = '{7'h40, 7'h20, 7'h14, 7'h12, 7'h0A, 7'h01};

    watchdog_timeout_reset u_watchdog_timeout_reset (
        .SYS_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .RESET_VECTOR_LO_I(vec), .WATCHDOG_DISABLE_BIT_I(dis),
        .LONG_TIMEOUT_SELECT_I(lng), .MONITOR_MODE_I(mon), .BREAK_STATE_I(brk),
        .WAIT_MODE_I(wt), .STOP_MODE_I(stp), .STOP_EXEC_I(sexec), .INTERNAL_RESET_I(irst),
        .HV_IRQ_PIN_I(hvi), .HV_RST_PIN_I(hvr), .RST_PIN_I(pin), .RST_PIN_O(pdrv),
        .RST_PIN_OE_O(oe), .WDOG_RESET_O(wrst), .CAUSE_EVENT_O(cev));
    wdt_reset_partner u_wdt_reset_partner (
        .clk_i(clk), .nrst_i(nrst), .pin_oe_i(oe), .pin_drive_i(pdrv),
        .wdog_reset_i(wrst), .pin_level_o(pin), .internal_reset_o(irst));

    // ----------------------------------------------------------------------
    // Clock, hang guard and verdict
    // ----------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run is about 75000 cycles, so this only trips on a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            miscompares++;
            results();
        end
    end

    task automatic results();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------------
    // Bus cycles and comparisons
    // ----------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e, input string what);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(what, e, rdata);
    endtask

    // Bounded wait for the reset, then its length; bits 2:0 survive a service
    task automatic expect_fire();
        n = 0;
        #1;
        while (n < 8200 && wrst !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("timeout window", 1, n >= 8166 && n <= 8178);
        check("reset pin level", 0, pin);
        n = 0;
        while (n < 40 && wrst === 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("reset pulse cycles", 32, n);
    endtask

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        void'($urandom(29432));
        {nrst, wr, rd, dis, mon, brk, wt, stp, sexec, hvi, hvr} = 11'h000;
        addr = 16'h0000;
        wdata = 8'h00;
        lng = 1'b1;
        vec = 8'($urandom);
        m = 8'($urandom);
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(16'hFE01, 8'h00, "cause after reset");
        rd_reg(16'hFFFF, vec, "vector low byte");
        rd_reg(16'h1234, 8'h00, "unmapped read");
        wr_reg(16'hFE02, m);
        rd_reg(16'hFE02, m & 8'h03, "mask");
        wr_reg(16'hFE02, 8'h00);
        // Wait mode must not stop the count
        wt <= 1'b1;
        repeat (4200) @(posedge clk);
        wr_reg(16'hFFFF, 8'($urandom));
        expect_fire();
        // A set mask bit lets its cause through; a clear one holds the event off
        check("masked event", 0, cev);
        wr_reg(16'hFE02, 8'h01);
        repeat (2) @(posedge clk);
        #1 check("cause event", 1, cev);
        rd_reg(16'hFE01, 8'h01, "cause flags");
        repeat (2) @(posedge clk);
        #1 check("cleared event", 0, cev);
        wr_reg(16'hFE02, 8'h00);
        // Each hold must keep the reset away for longer than a short timeout
        foreach (modes[i]) begin
            @(posedge clk);
            {lng, dis, mon, brk, hvi, hvr, stp} <= modes[i] ^ 7'h40;
            wr_reg(16'hFFFF, 8'($urandom));
            n = 0;
            repeat (9000) begin
                @(posedge clk);
                #1;
                n += wrst;
            end
            check("reset while held", 0, n);
        end
        // Still in stop: only the stop flag shows, and the monitor hold left its cause bit
        rd_reg(16'hFE03, 8'h04, "state in stop");
        rd_reg(16'hFE01, 8'h02, "hold entry cause");
        // Leaving stop after the stop instruction gives a full period again
        @(posedge clk);
        sexec <= 1'b1;
        @(posedge clk);
        sexec <= 1'b0;
        stp <= 1'b0;
        expect_fire();
        results();
    end
endmodule
